// ---- inc/ldjr_pkg.sv ----
package ldjr_pkg;
	// ****************************************************************
	// Opcodes
	// ****************************************************************
	localparam logic [3:0] JR_NIB      = 4'hb;
	localparam logic [3:0] LD_IM_NIB   = 4'hc;
	localparam logic [3:0] LD_RR_NIB   = 4'h8;
	localparam logic [3:0] LD_STR_NIB  = 4'h9;
	localparam logic [7:0] OP_BIT      = 8'h47;
	localparam logic [7:0] OP_IND_LD   = 8'hc3;
	localparam logic [7:0] OP_IND_ST   = 8'hd3;
	localparam logic [7:0] OP_SHORT_LD = 8'he7;
	localparam logic [7:0] OP_SHORT_ST = 8'hf7;
	localparam logic [7:0] OP_LONG_LD  = 8'ha7;
	localparam logic [7:0] OP_LONG_ST  = 8'hb7;
	localparam logic [7:0] OP_LD_GG    = 8'he4;
	localparam logic [7:0] OP_LD_GIM   = 8'he6;
	// ****************************************************************
	// Cycle counts and lengths
	// ****************************************************************
	localparam logic [3:0] CYC_JR    = 4'h6;
	localparam logic [3:0] CYC_BIT   = 4'h6;
	localparam logic [3:0] CYC_IND   = 4'ha;
	localparam logic [3:0] CYC_SHORT = 4'hc;
	localparam logic [3:0] CYC_LONG  = 4'he;
	localparam logic [3:0] CYC_LD2   = 4'h4;
	localparam logic [3:0] CYC_LD3   = 4'h6;
	localparam logic [3:0] CYC_NONE  = 4'h4;
	localparam logic [3:0] CNT_MAX   = 4'hf;
	// ****************************************************************
	// Flag positions
	// ****************************************************************
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	typedef enum logic [3:0] {K_NONE, K_JR, K_BIT, K_IND, K_SHORT, K_LONG,
		K_LD_IM, K_LD_RR, K_LD_STR, K_LD_GG, K_LD_GIM} kind_t;
	typedef enum logic [2:0] {S_IDLE, S_RDA, S_RDB, S_RDC, S_MEM, S_PAD} state_t;
endpackage

// ---- rtl/ldjr_exec.sv ----
`timescale 1ns/1ns
// How it works
// [RQ1] Taken condition adds displacement, else falls through
// [RQ2] Signed 8-bit displacement from next instruction
// [RQ3] Jump: two bytes, six cycles, cc nibble
// [RQ4] No flag bit ever written
// [RQ5] Plain load copies source, source untouched
// [RQ6] Bit load moves one bit, others kept
// [RQ7] Bit load opcode 47, three bytes, direction
// [RQ8] Memory move between register and memory
// [RQ9] Even pair program memory, odd data
// [RQ10] C3/D3 indirect, two bytes, ten cycles
// [RQ11] E7/F7 add one-byte index, twelve cycles
// [RQ12] A7/B7 add two-byte index, low first
// [RQ13] Pair 0-1 long form means direct address
// [RQ14] Program stores optional on masked parts
// [RQ15] Sixteen-entry condition table against flags
module ldjr_exec #(
	parameter bit PGM_WRITE_EN = 1'b1
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// Instruction in
	input  wire logic        instr_valid,
	output logic             instr_ready,
	input  wire logic [7:0]  instr_b0,
	input  wire logic [7:0]  instr_b1,
	input  wire logic [7:0]  instr_b2,
	input  wire logic [7:0]  instr_b3,
	input  wire logic [15:0] instr_pc,
	input  wire logic [7:0]  flags_in,
	input  wire logic [3:0]  work_page,
	// Completion
	output logic             exec_done,
	output logic [15:0]      pc_out,
	output logic             unsupported,
	output logic             flags_wr_en,
	// Register file
	output logic [7:0]       rf_rd_addr,
	input  wire logic [7:0]  rf_rd_data,
	output logic             rf_wr_en,
	output logic [7:0]       rf_wr_addr,
	output logic [7:0]       rf_wr_data,
	// Memory
	output logic             mem_req,
	output logic             mem_we,
	output logic             mem_data_sel,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  mem_rdata
);
	import ldjr_pkg::*;

	// ****************************************************************
	// Condition table
	// ****************************************************************
	function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
		logic base;
		base = 1'b0;
		case (cc[2:0])
			3'h0: base = 1'b0;
			3'h1: base = f[FLAG_S] ^ f[FLAG_V];
			3'h2: base = f[FLAG_Z] | (f[FLAG_S] ^ f[FLAG_V]);
			3'h3: base = f[FLAG_C] | f[FLAG_Z];
			3'h4: base = f[FLAG_V];
			3'h5: base = f[FLAG_S];
			3'h6: base = f[FLAG_Z];
			default: base = f[FLAG_C];
		endcase
		return base ^ cc[3]; // RQ15
	endfunction

	function automatic logic [7:0] work(input logic [3:0] pg, input logic [3:0] n);
		return {pg, n};
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	state_t      state_r, state_nxt;
	kind_t       kind_r, kind_nxt;
	logic [7:0]  b0_r, b0_nxt, b1_r, b1_nxt, b2_r, b2_nxt, b3_r, b3_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [3:0]  cyc_r, cyc_nxt, cnt_r, cnt_nxt, pg_r, pg_nxt;
	logic [7:0]  op_a_r, op_a_nxt, op_b_r, op_b_nxt;
	logic        unsup_r, unsup_nxt;
	logic        rfw_r, rfw_nxt;
	logic [7:0]  rfa_r, rfa_nxt, rfd_r, rfd_nxt;
	logic        mwe_r, mwe_nxt, msel_r, msel_nxt;
	logic [15:0] madr_r, madr_nxt;
	logic [7:0]  mwd_r, mwd_nxt;
	logic        is_mem, is_store, direct;
	logic [3:0]  rr;
	logic [15:0] idx;
	logic [15:0] disp;

	assign rr       = b1_r[3:0];
	assign is_mem   = (kind_r == K_IND) || (kind_r == K_SHORT) || (kind_r == K_LONG);
	assign is_store = b0_r[4];
	assign direct   = (kind_r == K_LONG) && (rr[3:1] == 3'h0); // RQ13
	assign idx      = (kind_r == K_LONG) ? {b3_r, b2_r} :
	                  (kind_r == K_SHORT) ? {8'h00, b2_r} : 16'h0000;
	assign disp     = {{8{instr_b1[7]}}, instr_b1}; // RQ2

	always_comb begin
		state_nxt = state_r;
		kind_nxt  = kind_r;
		b0_nxt    = b0_r;
		b1_nxt    = b1_r;
		b2_nxt    = b2_r;
		b3_nxt    = b3_r;
		pc_nxt    = pc_r;
		cyc_nxt   = cyc_r;
		pg_nxt    = pg_r;
		cnt_nxt   = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 4'h1;
		op_a_nxt  = op_a_r;
		op_b_nxt  = op_b_r;
		unsup_nxt = unsup_r;
		rfw_nxt   = 1'b0;
		rfa_nxt   = rfa_r;
		rfd_nxt   = rfd_r;
		mwe_nxt   = mwe_r;
		msel_nxt  = msel_r;
		madr_nxt  = madr_r;
		mwd_nxt   = mwd_r;
		rf_rd_addr = 8'h00;
		exec_done  = 1'b0;
		case (state_r)
			S_IDLE: begin
				cnt_nxt = 4'h1;
				if (instr_valid) begin
					b0_nxt    = instr_b0;
					b1_nxt    = instr_b1;
					b2_nxt    = instr_b2;
					b3_nxt    = instr_b3;
					pg_nxt    = work_page;
					unsup_nxt = 1'b0;
					state_nxt = S_RDA;
					if (instr_b0[3:0] == JR_NIB) begin
						kind_nxt = K_JR; // RQ3
						cyc_nxt  = CYC_JR;
						pc_nxt   = instr_pc + 16'h0002; // RQ2
						if (cond_true(instr_b0[7:4], flags_in))
							pc_nxt = instr_pc + 16'h0002 + disp; // RQ1
					end else if (instr_b0[3:0] == LD_IM_NIB) begin
						kind_nxt = K_LD_IM;
						cyc_nxt  = CYC_LD2;
						pc_nxt   = instr_pc + 16'h0002;
					end else if (instr_b0[3:0] == LD_RR_NIB) begin
						kind_nxt = K_LD_RR;
						cyc_nxt  = CYC_LD2;
						pc_nxt   = instr_pc + 16'h0002;
					end else if (instr_b0[3:0] == LD_STR_NIB) begin
						kind_nxt = K_LD_STR;
						cyc_nxt  = CYC_LD2;
						pc_nxt   = instr_pc + 16'h0002;
					end else begin
						case (instr_b0)
							OP_BIT: begin
								kind_nxt = K_BIT; // RQ7
								cyc_nxt  = CYC_BIT;
								pc_nxt   = instr_pc + 16'h0003;
							end
							OP_IND_LD, OP_IND_ST: begin
								kind_nxt = K_IND; // RQ10
								cyc_nxt  = CYC_IND;
								pc_nxt   = instr_pc + 16'h0002;
							end
							OP_SHORT_LD, OP_SHORT_ST: begin
								kind_nxt = K_SHORT; // RQ11
								cyc_nxt  = CYC_SHORT;
								pc_nxt   = instr_pc + 16'h0003;
							end
							OP_LONG_LD, OP_LONG_ST: begin
								kind_nxt = K_LONG; // RQ12
								cyc_nxt  = CYC_LONG;
								pc_nxt   = instr_pc + 16'h0004;
							end
							OP_LD_GG, OP_LD_GIM: begin
								kind_nxt = (instr_b0 == OP_LD_GG) ? K_LD_GG : K_LD_GIM;
								cyc_nxt  = CYC_LD3;
								pc_nxt   = instr_pc + 16'h0003;
							end
							default: begin
								kind_nxt  = K_NONE;
								cyc_nxt   = CYC_NONE;
								unsup_nxt = 1'b1;
								pc_nxt    = instr_pc + 16'h0001;
							end
						endcase
					end
				end
			end
			S_RDA: begin
				rf_rd_addr = (kind_r == K_BIT) ? work(pg_r, b1_r[7:4]) :
				             work(pg_r, {rr[3:1], 1'b0}); // RQ9
				op_a_nxt   = rf_rd_data;
				state_nxt  = S_RDB;
			end
			S_RDB: begin
				rf_rd_addr = (kind_r == K_BIT) ? b2_r :
				             is_mem ? work(pg_r, {rr[3:1], 1'b1}) : b1_r;
				op_b_nxt   = rf_rd_data;
				state_nxt  = S_RDC;
			end
			S_RDC: begin
				rf_rd_addr = (kind_r == K_LD_STR) ? work(pg_r, b0_r[7:4]) :
				             work(pg_r, b1_r[7:4]);
				state_nxt  = S_PAD;
				case (kind_r)
					K_BIT: begin
						rfw_nxt = 1'b1; // RQ6
						if (!b1_r[0]) begin
							rfa_nxt = work(pg_r, b1_r[7:4]);
							rfd_nxt = {op_a_r[7:1], op_b_r[b1_r[3:1]]};
						end else begin
							rfa_nxt = b2_r;
							rfd_nxt = op_b_r;
							rfd_nxt[b1_r[3:1]] = op_a_r[0];
						end
					end
					K_LD_IM: begin
						rfw_nxt = 1'b1; // RQ5
						rfa_nxt = work(pg_r, b0_r[7:4]);
						rfd_nxt = b1_r;
					end
					K_LD_RR: begin
						rfw_nxt = 1'b1; // RQ5
						rfa_nxt = work(pg_r, b0_r[7:4]);
						rfd_nxt = op_b_r;
					end
					K_LD_STR: begin
						rfw_nxt = 1'b1; // RQ5
						rfa_nxt = b1_r;
						rfd_nxt = rf_rd_data;
					end
					K_LD_GG: begin
						rfw_nxt = 1'b1; // RQ5
						rfa_nxt = b2_r;
						rfd_nxt = op_b_r;
					end
					K_LD_GIM: begin
						rfw_nxt = 1'b1; // RQ5
						rfa_nxt = b1_r;
						rfd_nxt = b2_r;
					end
					K_IND, K_SHORT, K_LONG: begin
						madr_nxt = direct ? {b3_r, b2_r} : {op_a_r, op_b_r} + idx; // RQ12
						msel_nxt = rr[0]; // RQ9
						mwe_nxt  = is_store; // RQ8
						mwd_nxt  = rf_rd_data;
						if (!(is_store && !rr[0] && !PGM_WRITE_EN))
							state_nxt = S_MEM; // RQ14
					end
					default: state_nxt = S_PAD;
				endcase
			end
			S_MEM: begin
				if (mem_ack) begin
					if (!mwe_r) begin
						rfw_nxt = 1'b1; // RQ8
						rfa_nxt = work(pg_r, b1_r[7:4]);
						rfd_nxt = mem_rdata;
					end
					state_nxt = S_PAD;
				end
			end
			S_PAD: begin
				if (cnt_r >= cyc_r) begin
					exec_done = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
			kind_r  <= K_NONE;
			b0_r    <= 8'h00;
			b1_r    <= 8'h00;
			b2_r    <= 8'h00;
			b3_r    <= 8'h00;
			pc_r    <= 16'h0000;
			cyc_r   <= 4'h0;
			cnt_r   <= 4'h0;
			pg_r    <= 4'h0;
			op_a_r  <= 8'h00;
			op_b_r  <= 8'h00;
			unsup_r <= 1'b0;
			rfw_r   <= 1'b0;
			rfa_r   <= 8'h00;
			rfd_r   <= 8'h00;
			mwe_r   <= 1'b0;
			msel_r  <= 1'b0;
			madr_r  <= 16'h0000;
			mwd_r   <= 8'h00;
		end else if (clk_en) begin
			state_r <= state_nxt;
			kind_r  <= kind_nxt;
			b0_r    <= b0_nxt;
			b1_r    <= b1_nxt;
			b2_r    <= b2_nxt;
			b3_r    <= b3_nxt;
			pc_r    <= pc_nxt;
			cyc_r   <= cyc_nxt;
			cnt_r   <= cnt_nxt;
			pg_r    <= pg_nxt;
			op_a_r  <= op_a_nxt;
			op_b_r  <= op_b_nxt;
			unsup_r <= unsup_nxt;
			rfw_r   <= rfw_nxt;
			rfa_r   <= rfa_nxt;
			rfd_r   <= rfd_nxt;
			mwe_r   <= mwe_nxt;
			msel_r  <= msel_nxt;
			madr_r  <= madr_nxt;
			mwd_r   <= mwd_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign instr_ready  = (state_r == S_IDLE);
	assign pc_out       = pc_r;
	assign unsupported  = unsup_r;
	assign flags_wr_en  = 1'b0; // RQ4
	assign rf_wr_en     = rfw_r & clk_en;
	assign rf_wr_addr   = rfa_r;
	assign rf_wr_data   = rfd_r;
	assign mem_req      = (state_r == S_MEM);
	assign mem_we       = mwe_r;
	assign mem_data_sel = msel_r;
	assign mem_addr     = madr_r;
	assign mem_wdata    = mwd_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	jr_taken_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ1
		(clk_en && instr_ready && instr_valid && instr_b0[3:0] == JR_NIB
		 && cond_true(instr_b0[7:4], flags_in)) |=>
		pc_out == $past(instr_pc) + 16'h0002 + {{8{$past(instr_b1[7])}}, $past(instr_b1)})
		else $error("taken jump target wrong");
	jr_cycles_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ3
		(clk_en && instr_ready && instr_valid && instr_b0[3:0] == JR_NIB) ##1 clk_en [*6]
		|-> exec_done)
		else $error("jump did not finish in six cycles");
	flags_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ4
		exec_done |-> !flags_wr_en)
		else $error("flags written");
	bit_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ6
		(rf_wr_en && kind_r == K_BIT && !b1_r[0]) |-> rf_wr_data[7:1] == op_a_r[7:1])
		else $error("bit load disturbed other bits");
	store_src_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ8
		(rf_wr_en && is_mem) |-> !mwe_r)
		else $error("store wrote register file");
	mem_space_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ9
		(mem_req && !direct) |-> mem_data_sel == rr[0])
		else $error("memory space select wrong");
	mem_cycles_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ10
		(exec_done && kind_r == K_IND) |-> cnt_r >= CYC_IND)
		else $error("indirect move too short");
	long_addr_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ12
		(mem_req && kind_r == K_LONG && !direct) |->
		mem_addr == {op_a_r, op_b_r} + {b3_r, b2_r})
		else $error("long index address wrong");
	direct_addr_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ13
		(mem_req && direct) |-> mem_addr == {b3_r, b2_r} && mem_data_sel == rr[0])
		else $error("direct address wrong");
	rom_store_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ14
		(mem_req && mem_we && !PGM_WRITE_EN) |-> mem_data_sel)
		else $error("program store on masked part");
endmodule

// ---- sim/ldjr_exec_bench.sv ----
`timescale 1ns/1ns
module load_and_relative_jump_exec_bench;
	import ldjr_pkg::*;
	// ****************************************************************
	// Ports and models
	// ****************************************************************
	logic        core_clk    = 1'b0;
	logic        rst_b       = 1'b0;
	logic        instr_valid = 1'b0;
	logic [7:0]  instr_b0    = 8'h00;
	logic [7:0]  instr_b1    = 8'h00;
	logic [7:0]  instr_b2    = 8'h00;
	logic [7:0]  instr_b3    = 8'h00;
	logic [15:0] instr_pc    = 16'h0000;
	logic [7:0]  flags_in    = 8'h00;
	logic [3:0]  work_page   = 4'h0;
	logic        mem_ack     = 1'b0;
	logic [7:0]  mem_rdata   = 8'h00;
	logic        instr_ready, exec_done, unsupported, flags_wr_en;
	logic        rf_wr_en, mem_req, mem_we, mem_data_sel, req_q;
	logic [15:0] pc_out, mem_addr;
	logic [7:0]  rf_rd_addr, rf_rd_data, rf_wr_addr, rf_wr_data, mem_wdata;
	logic [7:0]  rf [256];
	logic [7:0]  pmem [65536];
	logic [7:0]  dmem [65536];
	logic [3:0]  pg = 4'h0;
	int          failures = 0;
	int          n_checks = 0;
	int          mem_wait = 0;
	int          wcnt = 0;

	ldjr_exec i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .instr_b0(instr_b0),
		.instr_b1(instr_b1), .instr_b2(instr_b2), .instr_b3(instr_b3),
		.instr_pc(instr_pc), .flags_in(flags_in), .work_page(work_page),
		.exec_done(exec_done), .pc_out(pc_out), .unsupported(unsupported),
		.flags_wr_en(flags_wr_en), .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data),
		.rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
		.mem_req(mem_req), .mem_we(mem_we), .mem_data_sel(mem_data_sel),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	always #2 core_clk = ~core_clk;
	assign rf_rd_data = rf[rf_rd_addr];
	always @(posedge core_clk) begin
		if (rf_wr_en === 1'b1)
			rf[rf_wr_addr] <= rf_wr_data;
	end
	// Request seen mid-cycle, away from the launching edge
	always @(negedge core_clk) req_q <= mem_req;
	always @(posedge core_clk) begin
		if (mem_ack) begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wcnt      <= 0;
		end else if (req_q === 1'b1) begin
			if (wcnt >= mem_wait) begin
				mem_ack <= 1'b1;
				if (mem_we && mem_data_sel)
					dmem[mem_addr] <= mem_wdata;
				else if (mem_we)
					pmem[mem_addr] <= mem_wdata;
				else
					mem_rdata <= mem_data_sel ? dmem[mem_addr] : pmem[mem_addr];
			end else
				wcnt <= wcnt + 1;
		end
	end
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic run(input logic [7:0] b0, b1, b2, b3, input logic [15:0] ipc,
			input logic [7:0] fl, output int cyc, output logic [15:0] pc);
		logic r;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_b0    <= b0;
		instr_b1    <= b1;
		instr_b2    <= b2;
		instr_b3    <= b3;
		instr_pc    <= ipc;
		flags_in    <= fl;
		work_page   <= pg;
		do begin
			@(negedge core_clk);
			r = instr_ready;
			@(posedge core_clk);
		end while (r !== 1'b1);
		instr_valid <= 1'b0;
		cyc = 1;
		#1;
		while (exec_done !== 1'b1 && cyc < 40) begin
			@(posedge core_clk);
			#1;
			cyc++;
		end
		pc = pc_out;
		chk("flags write", {15'h0, flags_wr_en}, 16'h0);
		@(posedge core_clk);
		#1;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_jr();
		logic [23:0] tab [7] = '{24'h8007f1, 24'h0ff7f0, 24'h780801, 24'h77f800,
			24'hf80100, 24'h640f01, 24'he40f00};
		logic [7:0]  d;
		logic [15:0] exp, pc;
		int          cyc;
		for (int i = 0; i < 7; i++) begin
			d   = tab[i][11:4];
			exp = 16'h1ff2 + (tab[i][0] ? {{8{d[7]}}, d} : 16'h0);
			run({tab[i][23:20], JR_NIB}, d, 8'h00, 8'h00, 16'h1ff0, tab[i][19:12], cyc, pc);
			chk("jump pc", pc, exp);
			chk("jump cycles", cyc[15:0], 16'h6);
		end
		$display("Test jump relative done");
	endtask

	task automatic t_ld();
		logic [7:0]  e;
		logic [15:0] pc;
		int          cyc;
		pg = 4'hc;
		run({4'h5, LD_IM_NIB}, 8'ha5, 8'h00, 8'h00, 16'h0100, 8'hff, cyc, pc);
		chk("load imm", {8'h0, rf[8'hc5]}, 16'h00a5);
		chk("load imm cycles", cyc[15:0], 16'h4);
		chk("load imm pc", pc, 16'h0102);
		e = rf[8'h20];
		run(OP_LD_GG, 8'h20, 8'h31, 8'h00, 16'h0100, 8'h00, cyc, pc);
		chk("load dst", {8'h0, rf[8'h31]}, {8'h0, e});
		chk("load src", {8'h0, rf[8'h20]}, {8'h0, e});
		chk("load gg cycles", cyc[15:0], 16'h6);
		chk("load gg pc", pc, 16'h0103);
		e = rf[8'h40];
		run({4'h6, LD_RR_NIB}, 8'h40, 8'h00, 8'h00, 16'h0100, 8'h00, cyc, pc);
		chk("load to work", {8'h0, rf[8'hc6]}, {8'h0, e});
		e = rf[8'hc7];
		run({4'h7, LD_STR_NIB}, 8'h41, 8'h00, 8'h00, 16'h0100, 8'h00, cyc, pc);
		chk("load from work", {8'h0, rf[8'h41]}, {8'h0, e});
		run(OP_LD_GIM, 8'h33, 8'h5e, 8'h00, 16'h0100, 8'h00, cyc, pc);
		chk("load gim dst", {8'h0, rf[8'h33]}, 16'h005e);
		chk("load gim cycles", cyc[15:0], 16'h6);
		run(8'h00, 8'h00, 8'h00, 8'h00, 16'h0100, 8'h00, cyc, pc);
		chk("undecoded flag", {15'h0, unsupported}, 16'h1);
		chk("undecoded pc", pc, 16'h0101);
		$display("Test plain load done");
	endtask

	task automatic bit_case(input logic [3:0] r, input logic [2:0] b, input logic dir,
			input logic [7:0] g, rv, gv);
		logic [7:0]  er, eg;
		logic [15:0] pc;
		int          cyc;
		rf[{pg, r}] = rv;
		rf[g]       = gv;
		er          = rv;
		eg          = gv;
		if (dir)
			eg[b] = rv[0];
		else
			er[0] = gv[b];
		run(OP_BIT, {r, b, dir}, g, 8'h00, 16'h0200, 8'h00, cyc, pc);
		chk("bit work reg", {8'h0, rf[{pg, r}]}, {8'h0, er});
		chk("bit general reg", {8'h0, rf[g]}, {8'h0, eg});
		chk("bit cycles", cyc[15:0], 16'h6);
		chk("bit pc", pc, 16'h0203);
	endtask

	task automatic mem_case(input logic [7:0] op, input logic [3:0] r, n,
			input logic [7:0] b2, b3, input int w);
		logic [15:0] a, pc, nb;
		logic [3:0]  nc;
		logic [7:0]  src;
		logic        st;
		int          cyc;
		st = (op == OP_IND_ST) || (op == OP_SHORT_ST) || (op == OP_LONG_ST);
		a  = {rf[{pg, n & 4'he}], rf[{pg, n | 4'h1}]};
		nb = 16'h2;
		nc = CYC_IND;
		if (op == OP_SHORT_LD || op == OP_SHORT_ST) begin
			a  = a + {8'h0, b2};
			nb = 16'h3;
			nc = CYC_SHORT;
		end
		if (op == OP_LONG_LD || op == OP_LONG_ST) begin
			a  = (n[3:1] == 3'h0) ? {b3, b2} : a + {b3, b2};
			nb = 16'h4;
			nc = CYC_LONG;
		end
		// Store data differs from the old cell, so a lost write shows
		if (st)
			rf[{pg, r}] = ~(n[0] ? dmem[a] : pmem[a]);
		src      = st ? rf[{pg, r}] : (n[0] ? dmem[a] : pmem[a]);
		mem_wait = w;
		run(op, {r, n}, b2, b3, 16'h0300, 8'h00, cyc, pc);
		chk("mem dest", {8'h0, st ? (n[0] ? dmem[a] : pmem[a]) : rf[{pg, r}]},
			{8'h0, src});
		chk("mem source", {8'h0, st ? rf[{pg, r}] : (n[0] ? dmem[a] : pmem[a])},
			{8'h0, src});
		// Ack lands w cycles after the earliest slot; waits only stretch past the count
		chk("mem cycles", cyc[15:0], (16'(nc) > 16'(6 + w)) ? 16'(nc) : 16'(6 + w));
		chk("mem pc", pc, 16'h0300 + nb);
	endtask

	task automatic t_mem();
		pg = 4'h7;
		mem_case(OP_IND_LD, 4'h0, 4'h2, 8'h00, 8'h00, 0);
		mem_case(OP_IND_LD, 4'h0, 4'h3, 8'h00, 8'h00, 0);
		mem_case(OP_IND_ST, 4'h1, 4'h2, 8'h00, 8'h00, 0);
		mem_case(OP_IND_ST, 4'h1, 4'h3, 8'h00, 8'h00, 2);
		mem_case(OP_SHORT_LD, 4'h0, 4'h4, 8'hff, 8'h00, 0);
		mem_case(OP_SHORT_ST, 4'h1, 4'h5, 8'h01, 8'h00, 0);
		mem_case(OP_LONG_LD, 4'h2, 4'h6, 8'h00, 8'h10, 0);
		mem_case(OP_LONG_ST, 4'h3, 4'h7, 8'h34, 8'h12, 0);
		mem_case(OP_LONG_LD, 4'h2, 4'h0, 8'h04, 8'h11, 0);
		mem_case(OP_LONG_ST, 4'h3, 4'h1, 8'h05, 8'h11, 0);
		mem_case(OP_IND_LD, 4'h0, 4'h2, 8'h00, 8'h00, 8);
		$display("Test memory move done");
	endtask
	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		for (int i = 0; i < 65536; i++) begin
			pmem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
			dmem[i] = 8'(i) + 8'(i >> 8) + 8'h11;
		end
		for (int i = 0; i < 256; i++)
			rf[i] = 8'(i) ^ 8'h3c;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		t_jr();
		t_ld();
		bit_case(4'h0, 3'h2, 1'b0, 8'h20, 8'h06, 8'h05);
		bit_case(4'h1, 3'h0, 1'b1, 8'h21, 8'h06, 8'h05);
		bit_case(4'h2, 3'h7, 1'b1, 8'h22, 8'hff, 8'h7f);
		bit_case(4'h3, 3'h7, 1'b0, 8'h23, 8'h06, 8'h80);
		$display("Test bit load done");
		t_mem();
		stop_test();
	end

	initial begin
		#40000;
		failures++;
		stop_test();
	end
endmodule
